//--- hw/lmw_pkg.sv
package lmw_pkg;

    typedef enum logic [1:0] {
        LMW_MODE_OFF  = 2'h0,
        LMW_MODE_WAKE = 2'h1,
        LMW_MODE_RXO  = 2'h2,
        LMW_MODE_NORM = 2'h3
    } lmw_mode_type;

    typedef enum logic [2:0] {
        LMW_CHIP_NORMAL   = 3'h0,
        LMW_CHIP_STOP     = 3'h1,
        LMW_CHIP_SLEEP    = 3'h2,
        LMW_CHIP_RESTART  = 3'h3,
        LMW_CHIP_FAILSAFE = 3'h4,
        LMW_CHIP_INIT     = 3'h5
    } lmw_chip_type;

    localparam int LMW_CLK_HZ = 10_000_000;
    // wake filter 30..150 us; least time rounds up
    localparam int LMW_WAKE_FILTER_US = 30;
    localparam int LMW_WAKE_CYC = (LMW_WAKE_FILTER_US * LMW_CLK_HZ + 999_999) / 1_000_000;
    // dominant time-outs 16..24 ms, 20 typ
    localparam int LMW_TIMEOUT_MS = 20;
    localparam int LMW_TIMEOUT_CYC = LMW_TIMEOUT_MS * (LMW_CLK_HZ / 1000);
    localparam int LMW_CNT_W = 18;
    localparam lmw_mode_type LMW_MODE_RESET = LMW_MODE_OFF;
    localparam logic LMW_LOW_SLOPE_RESET = 1'b0;
    localparam logic LMW_FLASH_RESET = 1'b0;

endpackage

//--- hw/lmw_channel.sv
`timescale 1ns/1ps
module lmw_channel
    import lmw_pkg::*;
#(
    parameter int TIMEOUT_CYC = LMW_TIMEOUT_CYC
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic         mode_wr,
    input  wire lmw_mode_type mode_wdata,
    input  wire logic         auto_wake,
    input  wire logic         auto_rearm,
    input  wire logic         bus_transmit_in,
    input  wire logic         bus_level,
    input  wire logic         supply_uv,
    output lmw_mode_type      mode,
    output logic              rx_pin,
    output logic              drive_dom,
    output logic              wake_pulse,
    output logic              fault_flag,
    input  wire logic         fault_clr
);
    logic                 armed;
    logic                 woken;
    logic                 bus_q;
    logic [LMW_CNT_W-1:0] wake_cnt;
    logic [LMW_CNT_W-1:0] tx_cnt;
    logic [LMW_CNT_W-1:0] bus_cnt;
    logic                 tx_block;
    logic                 tx_to_hit;
    logic                 bus_to_hit;
    logic                 wake_det;

    localparam logic [LMW_CNT_W-1:0] WAKE_N = LMW_CNT_W'(LMW_WAKE_CYC);
    localparam logic [LMW_CNT_W-1:0] TO_N   = LMW_CNT_W'(TIMEOUT_CYC);

    // mode field; fail-safe forces wake-capable
    always_ff @(posedge sys_clk) begin
        if (rst)
            mode <= LMW_MODE_RESET;
        else if (auto_wake)
            mode <= LMW_MODE_WAKE;
        else if (mode_wr)
            mode <= mode_wdata;
    end

    // arm state: a wake leaves the field at wake-capable but disarmed
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            armed <= 1'b0;
            woken <= 1'b0;
        end else if (auto_rearm) begin
            armed <= 1'b1;
            // rearm keeps the receive pin low; only a software mode change releases it
            if (mode_wr && !auto_wake && mode_wdata != LMW_MODE_WAKE)
                woken <= 1'b0;
        end else if (mode_wr && !auto_wake && mode_wdata != LMW_MODE_WAKE) begin
            armed <= 1'b0;
            woken <= 1'b0;
        end else if (mode_wr && mode != LMW_MODE_WAKE) begin
            armed <= 1'b1;
        end else if (auto_wake && mode != LMW_MODE_WAKE) begin
            armed <= 1'b1;
        end else if (wake_det) begin
            armed <= 1'b0;
            woken <= 1'b1;
        end
    end

    // wake filter: falling edge, long dominant, then rising edge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bus_q    <= 1'b1;
            wake_cnt <= '0;
        end else begin
            bus_q <= bus_level;
            if (bus_level)
                wake_cnt <= '0;
            else if (bus_q)
                wake_cnt <= LMW_CNT_W'(1);
            else if (wake_cnt != '1)
                wake_cnt <= wake_cnt + LMW_CNT_W'(1);
        end
    end
    assign wake_det = armed && mode == LMW_MODE_WAKE && !supply_uv && bus_level && !bus_q
                      && wake_cnt > WAKE_N;

    always_ff @(posedge sys_clk) begin
        if (rst)
            wake_pulse <= 1'b0;
        else
            wake_pulse <= wake_det;
    end

    // transmit dominant time-out blocks the driver until transmit releases
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_cnt   <= '0;
            tx_block <= 1'b0;
        end else if (bus_transmit_in) begin
            tx_cnt   <= '0;
            tx_block <= 1'b0;
        end else begin
            if (tx_cnt != TO_N)
                tx_cnt <= tx_cnt + LMW_CNT_W'(1);
            if (tx_to_hit)
                tx_block <= 1'b1;
        end
    end
    assign tx_to_hit = !bus_transmit_in && tx_cnt == TO_N - LMW_CNT_W'(1);

    always_ff @(posedge sys_clk) begin
        if (rst)
            bus_cnt <= '0;
        else if (bus_level || !(mode == LMW_MODE_NORM || mode == LMW_MODE_RXO))
            bus_cnt <= '0;
        else if (bus_cnt != TO_N)
            bus_cnt <= bus_cnt + LMW_CNT_W'(1);
    end
    assign bus_to_hit = !bus_level && (mode == LMW_MODE_NORM || mode == LMW_MODE_RXO)
                        && bus_cnt == TO_N - LMW_CNT_W'(1);

    // fault flag: set wins over clear
    always_ff @(posedge sys_clk) begin
        if (rst)
            fault_flag <= 1'b0;
        else if (tx_to_hit || bus_to_hit)
            fault_flag <= 1'b1;
        else if (fault_clr)
            fault_flag <= 1'b0;
    end

    // pins: driver only in normal mode, receiver off under undervoltage unless a wake is latched
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            drive_dom <= 1'b0;
            rx_pin    <= 1'b1;
        end else begin
            drive_dom <= mode == LMW_MODE_NORM && !supply_uv && !tx_block && !tx_to_hit
                         && !bus_transmit_in;
            if (woken || wake_det)
                rx_pin <= 1'b0;
            else if (supply_uv || mode == LMW_MODE_OFF || mode == LMW_MODE_WAKE)
                rx_pin <= 1'b1;
            else
                rx_pin <= bus_level;
        end
    end

    a_wake_pin_low: assert property (@(posedge sys_clk) disable iff (rst)
        wake_det |=> !rx_pin) else $error("rx pin not low after wake");
    a_no_rearm_self: assert property (@(posedge sys_clk) disable iff (rst)
        wake_det |=> !armed) else $error("armed after wake");
    a_wake_filter: assert property (@(posedge sys_clk) disable iff (rst)
        wake_det |-> $past(!bus_level, LMW_WAKE_CYC)) else $error("wake too short");
    a_off_no_wake: assert property (@(posedge sys_clk) disable iff (rst)
        mode == LMW_MODE_OFF |-> !wake_det) else $error("wake in off mode");
    a_rxo_no_drive: assert property (@(posedge sys_clk) disable iff (rst)
        $past(mode) == LMW_MODE_RXO && !$past(rst) |-> !drive_dom) else $error("drive in rx only");
    a_tx_block: assert property (@(posedge sys_clk) disable iff (rst)
        tx_to_hit |=> !drive_dom && fault_flag) else $error("tx time-out not handled");
    a_uv_stages: assert property (@(posedge sys_clk) disable iff (rst)
        supply_uv && !woken && !wake_det |=> !drive_dom && rx_pin) else $error("stages on under uv");
    a_bus_fault: assert property (@(posedge sys_clk) disable iff (rst)
        bus_to_hit |=> fault_flag) else $error("bus clamp not flagged");

    c_wake: cover property (@(posedge sys_clk) disable iff (rst) wake_det);
    c_tx_to: cover property (@(posedge sys_clk) disable iff (rst) tx_to_hit);
    c_bus_to: cover property (@(posedge sys_clk) disable iff (rst) bus_to_hit);
endmodule

//--- hw/lmw_top.sv
`timescale 1ns/1ps
module lmw_top
    import lmw_pkg::*;
#(
    parameter int TIMEOUT_CYC = LMW_TIMEOUT_CYC
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire lmw_chip_type chip_state,
    input  wire logic         spi_select_n,
    input  wire logic         chan_a_mode_wr,
    input  wire lmw_mode_type chan_a_mode_wdata,
    input  wire logic         chan_b_mode_wr,
    input  wire lmw_mode_type chan_b_mode_wdata,
    input  wire logic         low_slope_wr,
    input  wire logic         flash_wr,
    input  wire logic         cfg_wdata,
    input  wire logic         watchdog_on_bus_wake,
    input  wire logic         watchdog_enabled,
    input  wire logic         wake_status_clr,
    input  wire logic         chan_a_fault_clr,
    input  wire logic         chan_b_fault_clr,
    input  wire logic         chan_a_transmit_in,
    input  wire logic         chan_b_transmit_in,
    input  wire logic         chan_a_bus_level,
    input  wire logic         chan_b_bus_level,
    input  wire logic         transceiver_supply_uv,
    output lmw_mode_type      chan_a_mode_field,
    output lmw_mode_type      chan_b_mode_field,
    output logic              chan_a_receive_pin,
    output logic              chan_b_receive_pin,
    output logic              chan_a_bus_drive,
    output logic              chan_b_bus_drive,
    output logic              chan_a_fault_flag,
    output logic              chan_b_fault_flag,
    output logic [1:0]        wake_source_status,
    output logic              int_n,
    output logic              watchdog_enable_req,
    output logic              restart_req,
    output logic              low_slope_select,
    output logic              slope_control_off
);
    logic         a_wr;
    logic         b_wr;
    logic         auto_wake;
    logic         auto_rearm;
    logic         a_wake;
    logic         b_wake;
    logic         any_wake;
    logic         sel_q;
    logic         ls_pend;
    logic         fl_pend;
    lmw_chip_type chip_q;
    logic         in_ns;

    assign in_ns = chip_state == LMW_CHIP_NORMAL || chip_state == LMW_CHIP_STOP;

    // mode writes filtered by chip state
    function automatic logic mode_ok(input lmw_mode_type m, input lmw_chip_type c);
        logic ok;
        ok = 1'b0;
        unique case (m)
            LMW_MODE_OFF:  ok = 1'b1;
            LMW_MODE_WAKE: ok = c != LMW_CHIP_FAILSAFE && c != LMW_CHIP_INIT;
            LMW_MODE_RXO:  ok = c == LMW_CHIP_NORMAL || c == LMW_CHIP_STOP;
            LMW_MODE_NORM: ok = c == LMW_CHIP_NORMAL || c == LMW_CHIP_STOP;
        endcase
        return ok;
    endfunction

    assign a_wr = chan_a_mode_wr && mode_ok(chan_a_mode_wdata, chip_state);
    assign b_wr = chan_b_mode_wr && mode_ok(chan_b_mode_wdata, chip_state);
    assign auto_wake = chip_state == LMW_CHIP_FAILSAFE;

    // rearm on entry to stop, sleep or fail-safe
    always_ff @(posedge sys_clk) begin
        if (rst)
            chip_q <= LMW_CHIP_INIT;
        else
            chip_q <= chip_state;
    end
    assign auto_rearm = chip_state != chip_q && (chip_state == LMW_CHIP_STOP
                        || chip_state == LMW_CHIP_SLEEP || chip_state == LMW_CHIP_FAILSAFE);

    lmw_channel #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chan_a (
        .sys_clk         (sys_clk),
        .rst             (rst),
        .mode_wr         (a_wr),
        .mode_wdata      (chan_a_mode_wdata),
        .auto_wake       (auto_wake),
        .auto_rearm      (auto_rearm),
        .bus_transmit_in (chan_a_transmit_in),
        .bus_level       (chan_a_bus_level),
        .supply_uv       (transceiver_supply_uv),
        .mode            (chan_a_mode_field),
        .rx_pin          (chan_a_receive_pin),
        .drive_dom       (chan_a_bus_drive),
        .wake_pulse      (a_wake),
        .fault_flag      (chan_a_fault_flag),
        .fault_clr       (chan_a_fault_clr)
    );

    lmw_channel #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chan_b (
        .sys_clk         (sys_clk),
        .rst             (rst),
        .mode_wr         (b_wr),
        .mode_wdata      (chan_b_mode_wdata),
        .auto_wake       (auto_wake),
        .auto_rearm      (auto_rearm),
        .bus_transmit_in (chan_b_transmit_in),
        .bus_level       (chan_b_bus_level),
        .supply_uv       (transceiver_supply_uv),
        .mode            (chan_b_mode_field),
        .rx_pin          (chan_b_receive_pin),
        .drive_dom       (chan_b_bus_drive),
        .wake_pulse      (b_wake),
        .fault_flag      (chan_b_fault_flag),
        .fault_clr       (chan_b_fault_clr)
    );

    assign any_wake = a_wake || b_wake;

    // wake source flags, set wins over clear
    always_ff @(posedge sys_clk) begin
        if (rst)
            wake_source_status <= 2'h0;
        else
            wake_source_status <= (wake_source_status & {2{!wake_status_clr}}) | {b_wake, a_wake};
    end

    // interrupt only in normal/stop; restart request from sleep/fail-safe
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            int_n               <= 1'b1;
            restart_req         <= 1'b0;
            watchdog_enable_req <= 1'b0;
        end else begin
            int_n       <= !(any_wake && in_ns);
            restart_req <= any_wake && (chip_state == LMW_CHIP_SLEEP
                           || chip_state == LMW_CHIP_FAILSAFE);
            watchdog_enable_req <= any_wake && chip_state == LMW_CHIP_STOP
                                   && !watchdog_enabled && watchdog_on_bus_wake;
        end
    end

    // slope options latched in normal state, applied at select rising edge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sel_q             <= 1'b1;
            ls_pend           <= LMW_LOW_SLOPE_RESET;
            fl_pend           <= LMW_FLASH_RESET;
            low_slope_select  <= LMW_LOW_SLOPE_RESET;
            slope_control_off <= LMW_FLASH_RESET;
        end else begin
            sel_q <= spi_select_n;
            if (low_slope_wr && chip_state == LMW_CHIP_NORMAL)
                ls_pend <= cfg_wdata;
            if (flash_wr && chip_state == LMW_CHIP_NORMAL)
                fl_pend <= cfg_wdata;
            if (spi_select_n && !sel_q) begin
                low_slope_select  <= ls_pend;
                slope_control_off <= fl_pend;
            end
        end
    end

    a_int_only_ns: assert property (@(posedge sys_clk) disable iff (rst)
        !int_n |-> $past(in_ns)) else $error("interrupt outside normal/stop");
    a_wake_int: assert property (@(posedge sys_clk) disable iff (rst)
        any_wake && in_ns |=> !int_n && wake_source_status != 2'h0) else $error("wake not signalled");
    a_sleep_restart: assert property (@(posedge sys_clk) disable iff (rst)
        any_wake && chip_state == LMW_CHIP_SLEEP |=> restart_req && int_n) else $error("no restart");
    a_slope_at_cs: assert property (@(posedge sys_clk) disable iff (rst)
        !(spi_select_n && !sel_q) |=> $stable(low_slope_select)) else $error("slope changed early");
    a_wd_on_wake: assert property (@(posedge sys_clk) disable iff (rst)
        watchdog_enable_req |-> $past(chip_state) == LMW_CHIP_STOP) else $error("watchdog outside stop");

    c_stop_wake: cover property (@(posedge sys_clk) disable iff (rst) any_wake && chip_state == LMW_CHIP_STOP);
    c_sleep_wake: cover property (@(posedge sys_clk) disable iff (rst) restart_req);
endmodule

//--- test/lmw_bus_node.sv
`timescale 1ns/1ps
module lmw_bus_node (
    input  wire logic drive_dom,
    input  wire logic remote_dom,
    output logic      bus_level
);
    // wired-and with pull-up: recessive unless some node pulls dominant
    assign bus_level = !(drive_dom || remote_dom);
endmodule

//--- test/lmw_top_tb.sv
`timescale 1ns/1ps
module lmw_top_tb;
    import lmw_pkg::*;
    localparam int TO = 50;
    localparam int MAX_CYC = 20000;
    logic         sys_clk = 1'b0, rst = 1'b1;
    lmw_chip_type cs = LMW_CHIP_NORMAL;
    lmw_mode_type ad = LMW_MODE_OFF, bd = LMW_MODE_OFF, am, bm, ea;
    logic         sel_n = 1'b1, awr = 1'b0, bwr = 1'b0, lsw = 1'b0, flw = 1'b0, cfg = 1'b0;
    logic         wdob = 1'b0, wden = 1'b1, wsclr = 1'b0, afc = 1'b0, bfc = 1'b0;
    logic         atx = 1'b1, btx = 1'b1, uv = 1'b0, arem = 1'b0, brem = 1'b0;
    logic         abus, bbus, arx, brx, adrv, bdrv, af, bf, intn, wdreq, rreq, lsel, soff;
    logic         saw_int, saw_rr, saw_wd;
    logic [1:0]   wss;
    int           fails = 0, n_compared = 0, cyc = 0;

    lmw_top #(.TIMEOUT_CYC(TO)) lmw_top_i (
        .sys_clk(sys_clk), .rst(rst), .chip_state(cs), .spi_select_n(sel_n),
        .chan_a_mode_wr(awr), .chan_a_mode_wdata(ad), .chan_b_mode_wr(bwr), .chan_b_mode_wdata(bd),
        .low_slope_wr(lsw), .flash_wr(flw), .cfg_wdata(cfg), .watchdog_on_bus_wake(wdob),
        .watchdog_enabled(wden), .wake_status_clr(wsclr), .chan_a_fault_clr(afc), .chan_b_fault_clr(bfc),
        .chan_a_transmit_in(atx), .chan_b_transmit_in(btx), .chan_a_bus_level(abus),
        .chan_b_bus_level(bbus), .transceiver_supply_uv(uv), .chan_a_mode_field(am),
        .chan_b_mode_field(bm), .chan_a_receive_pin(arx), .chan_b_receive_pin(brx),
        .chan_a_bus_drive(adrv), .chan_b_bus_drive(bdrv), .chan_a_fault_flag(af),
        .chan_b_fault_flag(bf), .wake_source_status(wss), .int_n(intn),
        .watchdog_enable_req(wdreq), .restart_req(rreq), .low_slope_select(lsel),
        .slope_control_off(soff));
    lmw_bus_node bus_a_i (.drive_dom(adrv), .remote_dom(arem), .bus_level(abus));
    lmw_bus_node bus_b_i (.drive_dom(bdrv), .remote_dom(brem), .bus_level(bbus));

    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic final_report();
        if (fails == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == MAX_CYC) begin
            fails++;
            final_report();
        end
    end

    task automatic chk(input logic got, input logic exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask

    task automatic chkm(input lmw_mode_type got, input lmw_mode_type exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t mode %0d want %0d", $time, got, exp);
        end
    endtask

    task automatic smp(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic ch, input lmw_mode_type m);
        @(posedge sys_clk);
        awr <= !ch;
        bwr <= ch;
        ad <= m;
        bd <= m;
        @(posedge sys_clk);
        awr <= 1'b0;
        bwr <= 1'b0;
        smp(2);
    endtask

    // remote node holds channel a dominant n cycles, then watch the aftermath
    task automatic pulse(input int n);
        @(posedge sys_clk);
        arem <= 1'b1;
        repeat (n) @(posedge sys_clk);
        arem <= 1'b0;
        {saw_int, saw_rr, saw_wd} = 3'h0;
        repeat (6) begin
            smp(1);
            if (intn === 1'b0) saw_int = 1'b1;
            if (rreq === 1'b1) saw_rr = 1'b1;
            if (wdreq === 1'b1) saw_wd = 1'b1;
        end
    endtask

    function automatic int longdom();
        return 310 + int'($urandom % 40);
    endfunction

    initial begin
        void'($urandom(34));
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        smp(1);
        chkm(am, LMW_MODE_OFF);
        chk(arx, 1'b1, "rx reset");
        chk(adrv, 1'b0, "drive reset");
        chk(intn, 1'b1, "int reset");
        chk(lsel, 1'b0, "slope reset");
        chk(soff, 1'b0, "flash reset");
        ea = LMW_MODE_OFF;
        for (int s = 0; s < 5; s++) begin
            for (int m = 0; m < 4; m++) begin
                @(posedge sys_clk);
                cs <= lmw_chip_type'(s);
                wr(1'b0, lmw_mode_type'(m));
                ea = (s == 4) ? LMW_MODE_WAKE : (m < 2 || s < 2) ? lmw_mode_type'(m) : ea;
                chkm(am, ea);
                chkm(bm, (s == 4) ? LMW_MODE_WAKE : LMW_MODE_OFF);
            end
        end
        @(posedge sys_clk);
        cs <= LMW_CHIP_NORMAL;
        wr(1'b0, LMW_MODE_NORM);
        smp(180);
        atx <= 1'b0;
        smp(2);
        chk(adrv, 1'b1, "drive");
        chk(arx, 1'b0, "rx follows bus");
        chk(brx, 1'b1, "rx b off");
        smp(TO + 2);
        chk(af, 1'b1, "tx timeout flag");
        chk(adrv, 1'b0, "tx timeout drive");
        chkm(am, LMW_MODE_NORM);
        atx <= 1'b1;
        smp(2);
        atx <= 1'b0;
        smp(2);
        chk(adrv, 1'b1, "drive back");
        atx <= 1'b1;
        afc <= 1'b1;
        smp(1);
        afc <= 1'b0;
        smp(2);
        chk(af, 1'b0, "fault clear");
        wr(1'b1, LMW_MODE_RXO);
        @(posedge sys_clk);
        btx <= 1'b0;
        brem <= 1'b1;
        smp(2);
        chk(bdrv, 1'b0, "rxo drive");
        chk(brx, 1'b0, "rxo rx");
        smp(TO + 5);
        chk(bf, 1'b1, "bus timeout");
        chk(af, 1'b0, "other channel");
        chkm(bm, LMW_MODE_RXO);
        brem <= 1'b0;
        btx <= 1'b1;
        uv <= 1'b1;
        arem <= 1'b1;
        atx <= 1'b0;
        smp(2);
        chk(adrv, 1'b0, "uv drive");
        chk(arx, 1'b1, "uv rx");
        atx <= 1'b1;
        uv <= 1'b0;
        smp(3);
        chk(arx, 1'b0, "uv over");
        chkm(am, LMW_MODE_NORM);
        arem <= 1'b0;
        wr(1'b0, LMW_MODE_WAKE);
        pulse(200);
        chk(saw_int, 1'b0, "short wake");
        chk(arx, 1'b1, "short rx");
        pulse(longdom());
        chk(saw_int, 1'b1, "wake int");
        chk(arx, 1'b0, "wake rx");
        chk(wss[0], 1'b1, "wake status");
        chkm(am, LMW_MODE_WAKE);
        @(posedge sys_clk);
        wsclr <= 1'b1;
        @(posedge sys_clk);
        wsclr <= 1'b0;
        pulse(longdom());
        chk(saw_int, 1'b0, "no rearm");
        wr(1'b0, LMW_MODE_OFF);
        chk(arx, 1'b1, "rx release");
        pulse(longdom());
        chk(saw_int, 1'b0, "off ignores");
        wr(1'b0, LMW_MODE_WAKE);
        pulse(longdom());
        chk(saw_int, 1'b1, "rearm");
        @(posedge sys_clk);
        cs <= LMW_CHIP_STOP;
        wden <= 1'b0;
        wdob <= 1'b1;
        pulse(longdom());
        chk(saw_int, 1'b1, "stop wake");
        chk(saw_wd, 1'b1, "watchdog");
        chk(saw_rr, 1'b0, "stop stays");
        @(posedge sys_clk);
        cs <= LMW_CHIP_SLEEP;
        wsclr <= 1'b1;
        @(posedge sys_clk);
        wsclr <= 1'b0;
        smp(1);
        chk(wss[0], 1'b0, "source cleared");
        pulse(longdom());
        chk(saw_rr, 1'b1, "sleep restart");
        chk(saw_int, 1'b0, "sleep no int");
        chk(arx, 1'b0, "sleep rx");
        chk(wss[0], 1'b1, "source");
        @(posedge sys_clk);
        cs <= LMW_CHIP_NORMAL;
        wr(1'b0, LMW_MODE_NORM);
        chk(arx, 1'b1, "normal rx");
        @(posedge sys_clk);
        cs <= LMW_CHIP_FAILSAFE;
        pulse(longdom());
        chkm(am, LMW_MODE_WAKE);
        chk(saw_rr, 1'b1, "failsafe restart");
        chk(saw_int, 1'b0, "failsafe int");
        @(posedge sys_clk);
        cs <= LMW_CHIP_NORMAL;
        sel_n <= 1'b0;
        lsw <= 1'b1;
        flw <= 1'b1;
        cfg <= 1'b1;
        smp(1);
        lsw <= 1'b0;
        flw <= 1'b0;
        smp(2);
        chk(lsel, 1'b0, "slope early");
        sel_n <= 1'b1;
        smp(2);
        chk(lsel, 1'b1, "slope");
        chk(soff, 1'b1, "flash");
        cs <= LMW_CHIP_STOP;
        sel_n <= 1'b0;
        lsw <= 1'b1;
        cfg <= 1'b0;
        smp(1);
        lsw <= 1'b0;
        sel_n <= 1'b1;
        smp(2);
        chk(lsel, 1'b1, "slope in stop");
        final_report();
    end
endmodule
